// file: rtl/fpc_pkg.sv
// Overview of operation
// - Four independent channel units, each with its own button, LEDs and state.
// - A brief press toggles only that channel's polarity.
// - Minus LED lights while inverting, plus LED while non-inverting, on or off.
// - Holding a button about 1.5 s toggles that channel on or off.
// - The off LED lights while a channel is off and it adds nothing to the sum.
// - Holding any button about 5 s requests an offset autocalibration.
// - Calibration runs about a minute and ends after 10 s with no relay activity.
// - A request is refused when any input is above about 500 uV.
// - Each input lights its overload LED while its magnitude exceeds 10 V.
// - The output overload LED lights while the output exceeds 10 V.
// - Only switched-on channels reach the sum, each with its selected sign.
// - Polarity and on/off settings are restored from storage at power-on.
package fpc_pkg;

	localparam int NCH = 4;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ       = 100;
	localparam int TICK_US       = 1000;
	localparam int TICK_CYC      = TICK_US * CLK_MHZ;
	localparam int DEBOUNCE_MS   = 20;
	localparam int ONOFF_MS      = 1500;
	localparam int CAL_MS        = 5000;
	localparam int QUIET_MS      = 10000;
	localparam int CALRUN_MS     = 60000;
	localparam int MSW           = 17;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQST  = 8'h08;
	localparam logic [7:0] ADDR_IRQMSK = 8'h0C;
	localparam logic [7:0] ADDR_NVDATA = 8'h10;

	localparam int IRQ_BRIEF  = 0;
	localparam int IRQ_HOLD   = 4;
	localparam int IRQ_CALOK  = 8;
	localparam int IRQ_CALREJ = 9;
	localparam int IRQ_CALEND = 10;
	localparam int IRQ_W      = 11;

	localparam logic [3:0] POL_RST = 4'h0;
	localparam logic [3:0] ON_RST  = 4'hF;

	typedef enum logic [1:0] {
		BTN_IDLE = 2'b00,
		BTN_HELD = 2'b01,
		BTN_ONOFF = 2'b10,
		BTN_CALREQ = 2'b11
	} fpc_btn_t;

	typedef enum logic [1:0] {
		CAL_IDLE  = 2'b00,
		CAL_RUN   = 2'b01,
		CAL_QUIET = 2'b10
	} fpc_cal_t;

	typedef struct packed {
		logic [NCH-1:0] ledMinus;
		logic [NCH-1:0] ledPlus;
		logic [NCH-1:0] ledOff;
		logic [NCH-1:0] ledInOvl;
		logic           ledOutOvl;
	} fpc_leds_t;

endpackage : fpc_pkg

// file: rtl/fpc_front_panel.sv
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module fpc_front_panel (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic [3:0]           buttonN,
	input  wire logic [3:0]           inOverload,
	input  wire logic                 outOverload,
	input  wire logic [3:0]           inAboveCalLimit,
	input  wire logic                 relayActive,
	input  wire logic                 nvValid,
	input  wire logic [7:0]           nvData,
	output logic [3:0]                sumEnable,
	output logic [3:0]                sumInvert,
	output logic                      calStart,
	output logic                      calBusy,
	output fpc_pkg::fpc_leds_t        leds,
	output logic [7:0]                nvWrData,
	output logic                      nvWrite,
	output logic                      irq,
	input  wire logic [31:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [31:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);

	// ----------------------------------------------------------------
	// Millisecond tick and pin synchronisers
	// ----------------------------------------------------------------
	localparam int MSW_T = fpc_pkg::MSW;
	logic [MSW_T-1:0] divQ;
	logic             tick;
	logic [3:0]       btnS1Q;
	logic [3:0]       btnS2Q;
	logic [3:0]       ovS1Q;
	logic [3:0]       ovS2Q;
	logic             oovS1Q;
	logic             oovS2Q;
	logic [3:0]       sigS1Q;
	logic [3:0]       sigS2Q;
	logic             rlyS1Q;
	logic             rlyS2Q;

	assign tick = (divQ == MSW_T'(fpc_pkg::TICK_CYC - 1));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			divQ <= '0;
		end else if (tick) begin
			divQ <= '0;
		end else begin
			divQ <= divQ + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			btnS1Q <= '0;
			btnS2Q <= '0;
			ovS1Q  <= '0;
			ovS2Q  <= '0;
			oovS1Q <= 1'b0;
			oovS2Q <= 1'b0;
			sigS1Q <= '0;
			sigS2Q <= '0;
			rlyS1Q <= 1'b0;
			rlyS2Q <= 1'b0;
		end else begin
			btnS1Q <= ~buttonN;
			btnS2Q <= btnS1Q;
			ovS1Q  <= inOverload;
			ovS2Q  <= ovS1Q;
			oovS1Q <= outOverload;
			oovS2Q <= oovS1Q;
			sigS1Q <= inAboveCalLimit;
			sigS2Q <= sigS1Q;
			rlyS1Q <= relayActive;
			rlyS2Q <= rlyS1Q;
		end
	end

	// ----------------------------------------------------------------
	// Channel units
	// ----------------------------------------------------------------
	logic [3:0] polQ;
	logic [3:0] onQ;
	logic [3:0] briefEv;
	logic [3:0] holdEv;
	logic [3:0] calReqEv;
	logic [3:0] swPolTgl;
	logic [3:0] swOnTgl;
	logic       restoreQ;
	logic       calReq;

	genvar g;
	generate
		for (g = 0; g < fpc_pkg::NCH; g++) begin : gCh
			logic [4:0]       dbCntQ;
			logic             pressQ;
			logic [13:0]      holdCntQ;
			fpc_pkg::fpc_btn_t stQ;

			// Debounce: state follows the pin once stable long enough
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					dbCntQ <= '0;
					pressQ <= 1'b0;
				end else if (btnS2Q[g] == pressQ) begin
					dbCntQ <= '0;
				end else if (tick) begin
					if (dbCntQ == 5'(fpc_pkg::DEBOUNCE_MS - 1)) begin
						pressQ <= btnS2Q[g];
						dbCntQ <= '0;
					end else begin
						dbCntQ <= dbCntQ + 1'b1;
					end
				end
			end

			// Press classification by duration
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					stQ      <= fpc_pkg::BTN_IDLE;
					holdCntQ <= '0;
				end else begin
					case (stQ)
						fpc_pkg::BTN_IDLE: begin
							holdCntQ <= '0;
							if (pressQ) begin
								stQ <= fpc_pkg::BTN_HELD;
							end
						end
						fpc_pkg::BTN_HELD: begin
							if (!pressQ) begin
								stQ <= fpc_pkg::BTN_IDLE;
							end else if (tick) begin
								holdCntQ <= holdCntQ + 1'b1;
								if (holdCntQ == 14'(fpc_pkg::ONOFF_MS - 1)) begin
									stQ <= fpc_pkg::BTN_ONOFF;
								end
							end
						end
						fpc_pkg::BTN_ONOFF: begin
							if (!pressQ) begin
								stQ <= fpc_pkg::BTN_IDLE;
							end else if (tick) begin
								holdCntQ <= holdCntQ + 1'b1;
								if (holdCntQ == 14'(fpc_pkg::CAL_MS - 1)) begin
									stQ <= fpc_pkg::BTN_CALREQ;
								end
							end
						end
						fpc_pkg::BTN_CALREQ: begin
							if (!pressQ) begin
								stQ <= fpc_pkg::BTN_IDLE;
							end
						end
						default: begin
							stQ <= fpc_pkg::BTN_IDLE;
						end
					endcase
				end
			end

			assign briefEv[g] = (stQ == fpc_pkg::BTN_HELD) && !pressQ;
			assign holdEv[g] = (stQ == fpc_pkg::BTN_HELD) && pressQ && tick
				&& (holdCntQ == 14'(fpc_pkg::ONOFF_MS - 1));
			assign calReqEv[g] = (stQ == fpc_pkg::BTN_ONOFF) && pressQ && tick
				&& (holdCntQ == 14'(fpc_pkg::CAL_MS - 1));

			// Per-channel state, restored at power-on
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					polQ[g] <= fpc_pkg::POL_RST[g];
					onQ[g]  <= fpc_pkg::ON_RST[g];
				end else if (!restoreQ && nvValid) begin
					polQ[g] <= nvData[g];
					onQ[g]  <= nvData[4+g];
				end else if (!calBusy) begin
					polQ[g] <= polQ[g] ^ (briefEv[g] | swPolTgl[g]);
					onQ[g]  <= onQ[g] ^ (holdEv[g] | swOnTgl[g]);
				end
			end
		end
	endgenerate

	assign calReq = |calReqEv;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			restoreQ <= 1'b0;
		end else if (nvValid) begin
			restoreQ <= 1'b1;
		end
	end

	// Settings are written back to storage whenever they change after the first nvValid restore
	logic [7:0] lastQ;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lastQ   <= {fpc_pkg::ON_RST, fpc_pkg::POL_RST};
			nvWrite <= 1'b0;
		end else begin
			lastQ   <= {onQ, polQ};
			nvWrite <= restoreQ && ({onQ, polQ} != lastQ);
		end
	end
	assign nvWrData = lastQ;

	// ----------------------------------------------------------------
	// Outputs to summing switches and LEDs
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sumEnable <= '0;
			sumInvert <= '0;
			leds      <= '0;
		end else begin
			sumEnable       <= onQ & {4{!calBusy}};
			sumInvert       <= polQ;
			leds.ledMinus   <= polQ;
			leds.ledPlus    <= ~polQ;
			leds.ledOff     <= ~onQ;
			leds.ledInOvl   <= ovS2Q;
			leds.ledOutOvl  <= oovS2Q;
		end
	end

	// ----------------------------------------------------------------
	// Autocalibration sequencer
	// ----------------------------------------------------------------
	fpc_pkg::fpc_cal_t calQ;
	logic [16:0]       calCntQ;
	logic [13:0]       quietCntQ;
	logic              calOk;
	logic              calRej;
	logic              calEnd;

	assign calOk  = calReq && (calQ == fpc_pkg::CAL_IDLE) && !(|sigS2Q);
	assign calRej = calReq && (calQ == fpc_pkg::CAL_IDLE) && (|sigS2Q);
	assign calEnd = (calQ == fpc_pkg::CAL_QUIET) && tick
		&& (quietCntQ == 14'(fpc_pkg::QUIET_MS - 1));
	assign calBusy = (calQ != fpc_pkg::CAL_IDLE);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			calQ      <= fpc_pkg::CAL_IDLE;
			calCntQ   <= '0;
			quietCntQ <= '0;
			calStart  <= 1'b0;
		end else begin
			calStart <= calOk;
			case (calQ)
				fpc_pkg::CAL_IDLE: begin
					calCntQ   <= '0;
					quietCntQ <= '0;
					if (calOk) begin
						calQ <= fpc_pkg::CAL_RUN;
					end
				end
				fpc_pkg::CAL_RUN: begin
					if (tick) begin
						calCntQ <= calCntQ + 1'b1;
					end
					if (tick && calCntQ == 17'(fpc_pkg::CALRUN_MS - 1)) begin
						calQ <= fpc_pkg::CAL_QUIET;
					end
				end
				fpc_pkg::CAL_QUIET: begin
					if (rlyS2Q) begin
						quietCntQ <= '0;
					end else if (calEnd) begin
						calQ <= fpc_pkg::CAL_IDLE;
					end else if (tick) begin
						quietCntQ <= quietCntQ + 1'b1;
					end
				end
				default: begin
					calQ <= fpc_pkg::CAL_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	logic [10:0] irqStQ;
	logic [10:0] irqMskQ;
	logic [10:0] irqSet;
	logic        wrEn;
	logic [31:0] wdQ;
	logic [7:0]  awQ;

	assign irqSet = {calEnd & !rlyS2Q, calRej, calOk, holdEv, briefEv};
	assign irq    = |(irqStQ & irqMskQ);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqStQ <= '0;
		end else if (wrEn && awQ == fpc_pkg::ADDR_IRQST) begin
			irqStQ <= (irqStQ & ~wdQ[10:0]) | irqSet;
		end else begin
			irqStQ <= irqStQ | irqSet;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic awHaveQ;
	logic wHaveQ;

	assign s_axi_awready = !awHaveQ && !s_axi_bvalid;
	assign s_axi_wready  = !wHaveQ && !s_axi_bvalid;
	assign wrEn          = awHaveQ && wHaveQ && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awHaveQ      <= 1'b0;
			wHaveQ       <= 1'b0;
			awQ          <= '0;
			wdQ          <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHaveQ <= 1'b1;
				awQ     <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHaveQ <= 1'b1;
				wdQ    <= s_axi_wdata & {{8{s_axi_wstrb[3]}},
					{8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
					{8{s_axi_wstrb[0]}}};
			end
			if (wrEn) begin
				awHaveQ      <= 1'b0;
				wHaveQ       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awQ == fpc_pkg::ADDR_CTRL
					|| awQ == fpc_pkg::ADDR_IRQST
					|| awQ == fpc_pkg::ADDR_IRQMSK) ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqMskQ <= '0;
		end else if (wrEn && awQ == fpc_pkg::ADDR_IRQMSK) begin
			irqMskQ <= wdQ[10:0];
		end
	end

	// Control writes: one-shot toggles of polarity and on/off
	assign swPolTgl = (wrEn && awQ == fpc_pkg::ADDR_CTRL) ? wdQ[3:0] : 4'h0;
	assign swOnTgl  = (wrEn && awQ == fpc_pkg::ADDR_CTRL) ? wdQ[7:4] : 4'h0;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'b00;
			case (s_axi_araddr[7:0])
				fpc_pkg::ADDR_CTRL: s_axi_rdata <= '0;
				fpc_pkg::ADDR_STATUS: s_axi_rdata <= {16'h0000, calQ,
					ovS2Q, oovS2Q, 1'b0, onQ, polQ};
				fpc_pkg::ADDR_IRQST: s_axi_rdata <= {21'h00_0000, irqStQ};
				fpc_pkg::ADDR_IRQMSK: s_axi_rdata <= {21'h00_0000, irqMskQ};
				fpc_pkg::ADDR_NVDATA: s_axi_rdata <= {24'h00_0000, lastQ};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : fpc_front_panel

// file: test/fpc_front_panel_checker.sv
`timescale 1ns/1ps
module fpc_front_panel_checker (
	input wire logic               clk,
	input wire logic               nrst,
	input wire logic [3:0]         inOverload,
	input wire logic               outOverload,
	input wire logic [3:0]         inAboveCalLimit,
	input wire logic [3:0]         sumEnable,
	input wire logic [3:0]         sumInvert,
	input wire logic               calStart,
	input wire logic               calBusy,
	input wire fpc_pkg::fpc_leds_t leds,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_bready,
	input wire logic               s_axi_rvalid,
	input wire logic               s_axi_rready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_pol_display: assert property ($past(nrst) |->
		(leds.ledMinus ^ leds.ledPlus) == 4'hF)
		else $error("plus and minus lamps not complementary");
	a_off_lamp: assert property ($past(nrst) && !calBusy
		&& !$past(calBusy) |-> leds.ledOff == ~sumEnable)
		else $error("off lamp disagrees with routing");
	a_sign_lamp: assert property ($stable(sumInvert) |->
		leds.ledMinus == sumInvert)
		else $error("routing sign disagrees with minus lamp");
	a_in_ovl_lamp: assert property (($stable(inOverload))[*5] |->
		leds.ledInOvl == inOverload)
		else $error("input overload lamp wrong");
	a_out_ovl_lamp: assert property (($stable(outOverload))[*5] |->
		leds.ledOutOvl == outOverload)
		else $error("output overload lamp wrong");
	a_cal_refused: assert property ((inAboveCalLimit != 4'h0)[*4] |->
		!calStart)
		else $error("calibration started with signal present");
	a_cal_start: assert property (calStart |=> !calStart && calBusy)
		else $error("calibration start not followed by busy");
	a_cal_mute: assert property (calBusy && $past(calBusy) |->
		sumEnable == 4'h0)
		else $error("channels routed during calibration");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid)
		else $error("write response dropped early");
	a_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid)
		else $error("read response dropped early");
endmodule : fpc_front_panel_checker

bind fpc_front_panel fpc_front_panel_checker fpc_front_panel_checker_inst (
	.clk(clk), .nrst(nrst), .inOverload(inOverload),
	.outOverload(outOverload), .inAboveCalLimit(inAboveCalLimit),
	.sumEnable(sumEnable), .sumInvert(sumInvert), .calStart(calStart),
	.calBusy(calBusy), .leds(leds), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready)
);

// file: test/fpc_operator.sv
`timescale 1ns/1ps
module fpc_operator (
	input wire logic       clk,
	input wire logic [3:0] press,
	output logic [3:0]     buttonN
);
	logic [3:0] last_q = 4'h0;
	logic [3:0] bounce_q = 4'h0;

	// Contacts chatter for a few cycles after each change
	always_ff @(posedge clk) begin
		last_q <= press;
		if (press != last_q)
			bounce_q <= 4'h8;
		else if (bounce_q != 4'h0)
			bounce_q <= bounce_q - 4'h1;
	end

	assign buttonN = bounce_q[0] ? press : ~press;
endmodule : fpc_operator

// file: test/fpc_front_panel_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
	begin \
		checks_done++; \
		if ((got) !== (ex)) begin \
			errors++; \
			$display("unexpected %s exp %h got %h", nm, ex, got); \
		end \
	end
module fpc_front_panel_tb;
	logic clk = 0, nrst = 0, outOvl = 0, nvValid = 0, irq;
	logic [3:0] press = 0, buttonN, inOvl = 0, above = 0;
	logic [3:0] sumEnable, sumInvert, pol, onE, aws = 0;
	logic [7:0] nvData = 8'h5A, nvWrData;
	fpc_pkg::fpc_leds_t leds;
	logic [31:0] awa = 0, wd = 0, ara = 0, rData, d;
	logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic awr, wr_, bv, arr, rv;
	logic [1:0] bResp, rResp, r;
	int errors = 0, checks_done = 0;
	int nvWrites = 0;
	logic nvWr, busy;

	always #5 clk = ~clk;

	// Counts storage write pulses, one per cycle in which the settings change
	always @(posedge clk)
		if (nvWr === 1'b1) nvWrites++;

	fpc_operator fpc_operator_inst (.clk(clk), .press(press),
		.buttonN(buttonN));

	fpc_front_panel fpc_front_panel_inst (.clk(clk), .nrst(nrst),
		.buttonN(buttonN), .inOverload(inOvl), .outOverload(outOvl),
		.inAboveCalLimit(above), .relayActive(1'b0), .nvValid(nvValid),
		.nvData(nvData), .sumEnable(sumEnable), .sumInvert(sumInvert),
		.calStart(), .calBusy(busy), .leds(leds), .nvWrData(nvWrData),
		.nvWrite(nvWr), .irq(irq), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(aws),
		.s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bResp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rv), .s_axi_rready(rr));

	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		awa <= 32'(a);
		wd <= v;
		aws <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awv && awr) awv <= 1'b0;
			if (wv && wr_) wv <= 1'b0;
		end while (bv !== 1'b1 && n < 50);
		br <= 1'b0;
		if (bv !== 1'b1) begin
			errors++;
			stop_test();
		end
		`CHK("bresp", er, bResp)
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ev,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		ara <= 32'(a);
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arv && arr) arv <= 1'b0;
		end while (rv !== 1'b1 && n < 50);
		d = rData;
		r = rResp;
		rr <= 1'b0;
		if (rv !== 1'b1) begin
			errors++;
			stop_test();
		end
		`CHK("rdata", ev, d)
		`CHK("rresp", er, r)
	endtask : rd

	function automatic logic [31:0] stat();
		return {18'h0_0000, inOvl, outOvl, 1'b0, onE, pol};
	endfunction : stat

	task automatic chk_state();
		rd(fpc_pkg::ADDR_STATUS, stat(), 2'b00);
		`CHK("sumEnable", onE, sumEnable)
		`CHK("sumInvert", pol, sumInvert)
		`CHK("ledMinus", pol, leds.ledMinus)
		`CHK("ledPlus", ~pol, leds.ledPlus)
		`CHK("ledOff", ~onE, leds.ledOff)
	endtask : chk_state

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		pol = fpc_pkg::POL_RST;
		onE = fpc_pkg::ON_RST;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		chk_state();
		@(posedge clk);
		nvValid <= 1'b1;
		@(posedge clk);
		nvValid <= 1'b0;
		pol = 4'hA;
		onE = 4'h5;
		repeat (4) @(posedge clk);
		chk_state();
		nvData <= 8'h00;
		nvValid <= 1'b1;
		repeat (4) @(posedge clk);
		chk_state();
		for (int i = 0; i < 8; i++) begin
			wr(fpc_pkg::ADDR_CTRL, 32'(1 << i), 4'hF, 2'b00);
			if (i < 4)
				pol[i] = ~pol[i];
			else
				onE[i-4] = ~onE[i-4];
			repeat (3) @(posedge clk);
			chk_state();
		end
		`CHK("nvWrData", {onE, pol}, nvWrData)
		`CHK("nvWrite", 9, nvWrites)
		wr(fpc_pkg::ADDR_CTRL, 32'h0000_00FF, 4'h0, 2'b00);
		repeat (3) @(posedge clk);
		chk_state();
		wr(fpc_pkg::ADDR_IRQMSK, 32'h0000_07FF, 4'h1, 2'b00);
		rd(fpc_pkg::ADDR_IRQMSK, 32'h0000_00FF, 2'b00);
		wr(fpc_pkg::ADDR_IRQST, 32'h0000_07FF, 4'hF, 2'b00);
		rd(fpc_pkg::ADDR_IRQST, 32'h0000_0000, 2'b00);
		`CHK("irq", 1'b0, irq)
		wr(8'h20, 32'h0000_0001, 4'hF, 2'b10);
		rd(8'h20, 32'h0000_0000, 2'b10);
		inOvl <= 4'h6;
		outOvl <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK("ledInOvl", 4'h6, leds.ledInOvl)
		`CHK("ledOutOvl", 1'b1, leds.ledOutOvl)
		chk_state();
		above <= 4'hF;
		press <= 4'h2;
		repeat (500) @(posedge clk);
		press <= 4'h0;
		above <= 4'h0;
		repeat (100) @(posedge clk);
		chk_state();
		`CHK("calBusy", 1'b0, busy)
		stop_test();
	end
endmodule : fpc_front_panel_tb
